// File: core/hpc_ctrl.sv
module hpc_ctrl
  import hpc_pkg::*;
#(
  parameter int PORTS = HPC_PORTS,
  parameter bit REDUCED = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire hpc_up_speed_t i_up_speed,
  input wire logic i_ganged_sel,
  input wire logic [2:0] i_strap_port_cnt,
  input wire logic i_cfg_cnt_wr,
  input wire logic [2:0] i_cfg_port_cnt,
  input wire hpc_cfg_wr_t i_cfg,
  input wire logic [PORTS-1:0] i_pwr_req,
  input wire logic [PORTS-1:0] i_may_off,
  input wire logic [PORTS-1:0] i_oc,
  input wire logic [PORTS-1:0] i_oc_ack,
  output hpc_port_speed_t [PORTS-1:0] o_port_speed,
  output logic [2:0] o_port_cnt,
  output logic [PORTS-1:0] o_pwr_on,
  output logic [PORTS-1:0] o_oc_flag,
  output logic [7:0] o_stat_cmd
);
  // ==========================================
  // reset synchroniser
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;
  // two stages so release aligns to clock
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  // any low on the pin holds the core at once
  assign rst_n = rst_s2_q & i_rstn;

  // ==========================================
  // mode and speed
  logic ganged;
  assign ganged = REDUCED ? 1'b1 : i_ganged_sel; // reduced variant

  hpc_port_speed_t speed_d;
  always_comb begin
    speed_d.ss_en = i_up_speed.ss;
    speed_d.hs_en = i_up_speed.ss | i_up_speed.hs;
  end

  // ==========================================
  // port count
  logic [2:0] cnt_q;
  logic strap_pend_q;
  // strap caught on first cycle after release; loader may override
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      cnt_q <= HPC_PORT_CNT_RST;
      strap_pend_q <= 1'b1;
    end else begin
      strap_pend_q <= 1'b0;
      if (i_cfg_cnt_wr && i_cfg_port_cnt >= 3'h1 && i_cfg_port_cnt <= 3'h4) begin
        cnt_q <= i_cfg_port_cnt;
      end else if (strap_pend_q && i_strap_port_cnt >= 3'h1 && i_strap_port_cnt <= 3'h4) begin
        cnt_q <= i_strap_port_cnt;
      end
    end
  end

  // ==========================================
  // status and command register
  logic [7:0] stat_q;
  // eeprom-sourced writes are dropped
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      stat_q <= HPC_STAT_CMD_RST;
    end else if (i_cfg.wr && !i_cfg.from_eeprom && i_cfg.addr == HPC_STAT_CMD_ADDR) begin
      stat_q <= i_cfg.data;
    end
  end

  // ==========================================
  // over-current flags and power
  logic [PORTS-1:0] ocf_q;
  logic [PORTS-1:0] pwr_q;
  hpc_port_speed_t [PORTS-1:0] spd_q;
  logic any_oc;
  logic any_req;
  logic all_off_ok;
  logic gang_on_q;
  logic [PORTS-1:0] act_mask;
  assign any_oc = |i_oc;
  assign any_req = |(i_pwr_req & act_mask);
  assign all_off_ok = &(i_may_off | ~act_mask);

  // ganged switch: off on any over-current, else on when any needs, off only when all allow
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n) begin
      gang_on_q <= 1'b0;
    end else if (any_oc) begin
      gang_on_q <= 1'b0;
    end else if (any_req) begin
      gang_on_q <= 1'b1;
    end else if (all_off_ok) begin
      gang_on_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      assign act_mask[g] = (3'(g) < cnt_q);
      // sticky flag, set wins over ack; ganged uses flag 0
      always_ff @(posedge i_sys_clk) begin
        if (!rst_n) begin
          ocf_q[g] <= 1'b0;
        end else if (ganged ? (g == 0 && any_oc) : i_oc[g]) begin
          ocf_q[g] <= 1'b1;
        end else if (i_oc_ack[g]) begin
          ocf_q[g] <= 1'b0;
        end
      end
      // power switch drive per mode
      always_ff @(posedge i_sys_clk) begin
        if (!rst_n) begin
          pwr_q[g] <= 1'b0;
        end else if (ganged) begin
          pwr_q[g] <= act_mask[g] & ~any_oc & (any_req | (gang_on_q & ~all_off_ok));
        end else begin
          pwr_q[g] <= act_mask[g] & i_pwr_req[g] & ~i_oc[g];
        end
      end
      // registered speed limits
      always_ff @(posedge i_sys_clk) begin
        if (!rst_n) begin
          spd_q[g] <= '0;
        end else begin
          spd_q[g] <= act_mask[g] ? speed_d : '0;
        end
      end
    end
  endgenerate

  // outputs come straight from flops
  assign o_port_speed = spd_q;
  assign o_port_cnt = cnt_q;
  assign o_pwr_on = pwr_q;
  assign o_oc_flag = ocf_q;
  assign o_stat_cmd = stat_q;

  // ==========================================
  // assertions
  // speed limits follow upstream capability
  a_ss_needs_up: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !i_up_speed.ss |=> !spd_q[0].ss_en)
    else $error("ss left enabled");
  a_hs_needs_up: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !(i_up_speed.ss | i_up_speed.hs) |=> !spd_q[0].hs_en)
    else $error("hs left on");

  // port count and unreported ports
  a_cnt_range: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    cnt_q >= 3'h1 && cnt_q <= 3'h4)
    else $error("port count out of range");
  a_cnt_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_cfg_cnt_wr && i_cfg_port_cnt >= 3'h1 && i_cfg_port_cnt <= 3'h4
    |=> cnt_q == $past(i_cfg_port_cnt))
    else $error("count write lost");
  a_idle_port_off: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !act_mask[3] |=> !pwr_q[3])
    else $error("unreported port powered");

  // per-port power
  a_pp_follow: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !ganged && act_mask[1] && i_pwr_req[1] && !i_oc[1] |=> pwr_q[1])
    else $error("port power not following request");
  a_pp_oc_local: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !ganged && i_oc[0] && !i_oc[1] && i_pwr_req[1] && act_mask[1] |=> !pwr_q[0] && pwr_q[1])
    else $error("over-current not local");

  // ganged power
  a_gang_on: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ganged && any_req && !any_oc |=> pwr_q[0])
    else $error("ganged power not on");
  a_gang_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ganged && gang_on_q && !all_off_ok && !any_oc |=> pwr_q[0])
    else $error("ganged power dropped early");
  a_gang_oc: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ganged && any_oc |=> pwr_q == '0)
    else $error("ganged oc left power");
  a_reduced: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    REDUCED && !i_ganged_sel && !i_pwr_req[0] && any_req && !any_oc |=> pwr_q[0])
    else $error("reduced variant not ganged");

  // configuration path
  a_no_eeprom: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_cfg.wr && i_cfg.from_eeprom |=> $stable(stat_q))
    else $error("eeprom wrote status");
  a_stat_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_cfg.wr && !i_cfg.from_eeprom && i_cfg.addr == HPC_STAT_CMD_ADDR
    |=> stat_q == $past(i_cfg.data))
    else $error("status write lost");

  // reset and flags
  a_rst_dflt: assert property (@(posedge i_sys_clk)
    !i_rstn |=> pwr_q == '0 && ocf_q == '0 && stat_q == HPC_STAT_CMD_RST)
    else $error("reset defaults wrong");
  a_sync_two: assert property (@(posedge i_sys_clk)
    $rose(i_rstn) |=> !rst_n ##1 (rst_n || !i_rstn))
    else $error("reset release not two stages");
  a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ocf_q[1] && !i_oc_ack[1] |=> ocf_q[1])
    else $error("flag lost");
  a_flag_set: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !ganged && i_oc[2] |=> ocf_q[2])
    else $error("flag not set");
  a_ack_clear: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !ganged && ocf_q[1] && i_oc_ack[1] && !i_oc[1] |=> !ocf_q[1])
    else $error("flag not cleared");

  // main scenarios
  c_gang_oc: cover property (@(posedge i_sys_clk) ganged && any_oc && gang_on_q);
  c_pp_oc: cover property (@(posedge i_sys_clk) !ganged && i_oc[2] && pwr_q[3]);
  c_fs_up: cover property (@(posedge i_sys_clk) !i_up_speed.ss && !i_up_speed.hs);
  c_cnt_write: cover property (@(posedge i_sys_clk) rst_n && i_cfg_cnt_wr && i_cfg_port_cnt == 3'h2);
  c_set_and_ack: cover property (@(posedge i_sys_clk) rst_n && !ganged && i_oc[0] && i_oc_ack[0]);
endmodule // hpc_ctrl

// File: core/hpc_pkg.sv
// What this block does
// - no superspeed downstream without upstream superspeed
// - full/low-speed upstream disables superspeed and high-speed
// - report one to four downstream ports
// - per-port mode follows host power request
// - per-port over-current cuts only that port
// - ganged power on when any port needs
// - ganged power off only when all allow
// - ganged over-current cuts all ports
// - reduced variant forces ganged power mode
// - eeprom load never writes status register
// - reset returns all registers to defaults
// - no function while reset asserted
// - all logic runs on one reference clock
package hpc_pkg;
  // ==========================================
  // constants
  localparam int HPC_PORTS = 4;
  localparam logic [7:0] HPC_STAT_CMD_ADDR = 8'hF8;
  localparam logic [7:0] HPC_STAT_CMD_RST = 8'h00;
  localparam logic [2:0] HPC_PORT_CNT_RST = 3'h4;
  localparam int HPC_RST_HOLD_MS = 3;
  localparam int HPC_CLK_MHZ = 24;
  // upstream speed capability, one bit per class
  typedef struct packed {
    logic ss;
    logic hs;
  } hpc_up_speed_t;
  // per-port allowed speeds
  typedef struct packed {
    logic ss_en;
    logic hs_en;
  } hpc_port_speed_t;
  // configuration write from eeprom/smbus loader
  typedef struct packed {
    logic       wr;
    logic       from_eeprom;
    logic [7:0] addr;
    logic [7:0] data;
  } hpc_cfg_wr_t;
endpackage : hpc_pkg

// File: test/hpc_ctrl_test.sv
// ==========================================
// bench top
module hpc_ctrl_test
  import hpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, gang = 0, cnt_wr = 0;
  hpc_up_speed_t up = '0;
  hpc_cfg_wr_t cfg = '0;
  hpc_port_speed_t [3:0] spd;
  logic [2:0] strap = 3'h3, cfg_cnt = 3'h0, cnt;
  logic [3:0] req = '0, may = '0, fault = '0, ack = '0, oc, pwr, flag, m_pwr, m_flag, act;
  logic [7:0] stat, m_spd, m_stat;
  logic m_on;
  logic [3:0] r_pwr, r_flag;
  int seed = 32'hc9df5179, miscompares = 0, compares = 0, e = 0, m_cnt, r;
  // free-running clock
  initial forever #4 clk = ~clk;
  hpc_ctrl i_hpc_ctrl (.i_sys_clk(clk), .i_rstn(rstn), .i_up_speed(up), .i_ganged_sel(gang),
    .i_strap_port_cnt(strap), .i_cfg_cnt_wr(cnt_wr), .i_cfg_port_cnt(cfg_cnt), .i_cfg(cfg),
    .i_pwr_req(req), .i_may_off(may), .i_oc(oc), .i_oc_ack(ack), .o_port_speed(spd),
    .o_port_cnt(cnt), .o_pwr_on(pwr), .o_oc_flag(flag), .o_stat_cmd(stat));
  hpc_sw_model i_hpc_sw_model (.i_pwr_on(pwr), .i_fault(fault), .o_oc(oc));
  // reduced variant fed the opposite mode select; must still behave ganged
  if (1) begin : g_red
    hpc_ctrl #(.PORTS(4), .REDUCED(1'b1)) i_hpc_ctrl (.i_sys_clk(clk), .i_rstn(rstn),
      .i_up_speed(up), .i_ganged_sel(~gang), .i_strap_port_cnt(strap), .i_cfg_cnt_wr(cnt_wr),
      .i_cfg_port_cnt(cfg_cnt), .i_cfg(cfg), .i_pwr_req(req), .i_may_off(may), .i_oc(oc),
      .i_oc_ack(ack), .o_port_speed(), .o_port_cnt(), .o_pwr_on(r_pwr), .o_oc_flag(r_flag),
      .o_stat_cmd());
  end
  // ==========================================
  // checking and verdict
  task chk(input string n, input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // reference model, advanced once per clock edge
  task upd;
    if (!rstn || e < 2) begin
      m_cnt = 4; m_pwr = '0; m_flag = '0; m_spd = '0; m_stat = '0; m_on = 0;
    end else begin
      act = 4'hF >> (4 - m_cnt);
      for (int p = 0; p < 4; p++) begin
        m_spd[2*p +: 2] = act[p] ? {up.ss & up.hs, up.hs} : 2'h0;
      end
      m_on = !(|oc) && (|(req & act) || (m_on && !(&(may | ~act))));
      if (gang) begin
        m_pwr = m_on ? act : 4'h0;
        m_flag[0] = |oc || (m_flag[0] && !ack[0]);
      end else begin
        m_pwr = req & ~oc & act;
        m_flag = oc | (m_flag & ~ack);
      end
      if (cfg.wr && !cfg.from_eeprom && cfg.addr == HPC_STAT_CMD_ADDR) m_stat = cfg.data;
      if (cnt_wr && cfg_cnt inside {[1:4]}) m_cnt = cfg_cnt;
      else if (e == 2 && strap inside {[1:4]}) m_cnt = strap;
    end
    e = rstn ? e + 1 : 0;
  endtask
  // one phase: reset held 11 cycles, then random traffic
  task cyc(input int n, input logic g, input logic [2:0] s);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      chk("cnt", 8'(cnt), 8'(m_cnt));
      chk("spd", 8'(spd), m_spd);
      chk("pwr", 8'(pwr), 8'(m_pwr));
      chk("flag", 8'(flag), 8'(m_flag));
      chk("stat", stat, m_stat);
      if (gang) begin
        chk("red_pwr", 8'(r_pwr), 8'(m_pwr));
        chk("red_flag", 8'(r_flag), 8'(m_flag));
      end
      rstn = (i >= 11);
      gang = g;
      strap = s;
      r = $random(seed);
      if (e >= 4) begin
        up = (r[1:0] == 2'h3) ? 2'h0 : {r[1], r[1] | r[0]};
        req = r[7:4];
        may = r[8] ? 4'hF : {r[3:2], r[9], r[16]};
        fault = (r[11:9] == 3'h0) ? r[15:12] : 4'h0;
        ack = (r[18:16] == 3'h0) ? r[22:19] : 4'h0;
        cfg = {r[23], r[24], r[25] ? HPC_STAT_CMD_ADDR : r[31:24], r[15:8]};
        cnt_wr = r[28:26] == 3'h0;
        cfg_cnt = r[31:29];
      end else begin
        {up, req, may, fault, ack, cfg, cnt_wr} = '0;
      end
      #5;
      upd;
    end
  endtask
  // per-port, ganged, per-port with a single port, then a refused strap
  initial begin
    upd;
    cyc(400, 1'b0, 3'h3);
    cyc(400, 1'b1, 3'h4);
    cyc(300, 1'b0, 3'h1);
    cyc(100, 1'b0, 3'h6);
    conclude;
  end
endmodule // hpc_ctrl_test

// File: test/hpc_sw_model.sv
// ==========================================
// downstream power switch model
module hpc_sw_model (
  input wire logic [3:0] i_pwr_on,
  input wire logic [3:0] i_fault,
  output logic [3:0] o_oc
);
  timeunit 1ns;
  timeprecision 1ns;
  // a shorted load trips its switch only while powered
  assign o_oc = i_pwr_on & i_fault;
endmodule // hpc_sw_model
